// ### include/pbsp_pkg.sv
package pbsp_pkg;
    localparam int LANES_DEFAULT     = 4;
    localparam int ADDR_W_DEFAULT    = 17;
    localparam int BYTE_W            = 8;
    localparam int LANE_W            = 9;
    localparam int BURST_W           = 2;
    localparam int DATA_LATENCY      = 2;
    localparam logic OE_N_RESET      = 1'b1;
    localparam logic [BURST_W-1:0] BURST_CNT_RESET = 2'h0;
    localparam logic [BURST_W-1:0] BURST_STEP      = 2'h1;

    typedef enum logic [2:0]
    {
        PBSP_IDLE  = 3'b001,
        PBSP_READ  = 3'b010,
        PBSP_WRITE = 3'b100
    } pbsp_state_e;
endpackage

// ### include/pbsp_mem_if.sv
interface pbsp_mem_if #(
    parameter int LANES  = 4,
    parameter int ADDR_W = 17
);
    localparam int LW = pbsp_pkg::LANE_W;
    logic                      wr_en;
    logic [ADDR_W-1:0]         wr_addr;
    logic [LANES-1:0]          wr_lane;
    logic [LANES*LW-1:0]       wr_data;
    logic                      rd_en;
    logic [ADDR_W-1:0]         rd_addr;
    logic [LANES*LW-1:0]       rd_data;

    modport ctrl (output wr_en, wr_addr, wr_lane, wr_data, rd_en, rd_addr, input rd_data);
    modport mem  (input wr_en, wr_addr, wr_lane, wr_data, rd_en, rd_addr, output rd_data);
endinterface

// ### design/pbsp_mem.sv
module pbsp_mem
    import pbsp_pkg::*;
#(
    parameter int LANES  = LANES_DEFAULT,
    parameter int ADDR_W = ADDR_W_DEFAULT
)(
    input  wire logic  clk_in,
    pbsp_mem_if.mem    port
);
    logic [LANE_W-1:0] store [LANES][2**ADDR_W];
    logic [LANES*LANE_W-1:0] rd_reg;

    assign port.rd_data = rd_reg;

    // write-first per lane so a read meeting a write to the same word sees new data
    for (genvar g = 0; g < LANES; g++)
    begin : g_lane
        always_ff @(posedge clk_in)
        begin
            if (port.wr_en && port.wr_lane[g])
            begin
                store[g][port.wr_addr] <= port.wr_data[g*LANE_W +: LANE_W];
            end
            if (port.rd_en)
            begin
                if (port.wr_en && port.wr_lane[g] && port.wr_addr == port.rd_addr)
                begin
                    rd_reg[g*LANE_W +: LANE_W] <= port.wr_data[g*LANE_W +: LANE_W];
                end
                else
                begin
                    rd_reg[g*LANE_W +: LANE_W] <= store[g][port.rd_addr];
                end
            end
        end
    end
endmodule

// ### design/pbsp_port.sv
// Summary of operation
// - read loaded in cycle n drives its data in cycle n+2 when output enabled
// - advance high in active burst steps counter and uses internal address
// - read/write input is ignored on advance cycles
// - burst direction is fixed by the level captured at load
// - load low with any select false starts a deselect cycle
// - deselect finishes pending transfers, bus floats two cycles later
// - selected only when both low selects low and high select high
// - suspend high freezes every register and the data pins
// - suspended cycle neither advances counter nor moves pipeline
// - data outputs float from the first clock edge in reset until a read drives them
// - lane one gates bits 0-7 and parity 1, lane two bits 8-15 and parity 2
// - wide build adds lane three bits 16-23, lane four bits 24-31
// - any lane mix writes at once; reads ignore lane enables
// - order input high: low address bits are start XOR beat count
// - order input low: low address bits add one per beat modulo four
// - after fourth beat counter wraps to loaded bits and keeps counting
module pbsp_port
    import pbsp_pkg::*;
#(
    parameter int LANES  = LANES_DEFAULT,
    parameter int ADDR_W = ADDR_W_DEFAULT
)(
    input  wire logic                    REF_CLK_IN,
    input  wire logic                    RESET_IN,
    input  wire logic [ADDR_W-1:0]       ADDR_IN,
    input  wire logic                    READ_WRITE_N_IN,
    input  wire logic                    ADVANCE_OR_LOAD_IN,
    input  wire logic                    CLOCK_SUSPEND_N_IN,
    input  wire logic                    SELECT_LOW_FIRST_N_IN,
    input  wire logic                    SELECT_LOW_SECOND_N_IN,
    input  wire logic                    SELECT_HIGH_SECOND_IN,
    input  wire logic [LANES-1:0]        BYTE_LANE_WRITE_N_IN,
    input  wire logic                    BURST_ORDER_SELECT_IN,
    input  wire logic                    OUTPUT_ENABLE_N_IN,
    input  wire logic [LANES*BYTE_W-1:0] DQ_IN,
    input  wire logic [LANES-1:0]        PARITY_IN,
    output logic      [LANES*BYTE_W-1:0] DQ_OUT,
    output logic      [LANES-1:0]        PARITY_OUT,
    output logic                         DATA_OE_N_OUT
);
    if (LANES != 2 && LANES != 4)
    begin : g_bad_lanes
        $error("pbsp_port: LANES must be 2 or 4");
    end
    if (ADDR_W < BURST_W + 1)
    begin : g_bad_addr
        $error("pbsp_port: ADDR_W too small");
    end

    pbsp_mem_if #(.LANES(LANES), .ADDR_W(ADDR_W)) mif ();

    pbsp_mem #(.LANES(LANES), .ADDR_W(ADDR_W)) u_mem
    (
        .clk_in (REF_CLK_IN),
        .port   (mif.mem)
    );

    pbsp_state_e             state_reg;
    logic [ADDR_W-1:0]       hi_addr_reg;
    logic [BURST_W-1:0]      base_reg;
    logic [BURST_W-1:0]      cnt_reg;
    logic [BURST_W-1:0]      cnt_next;
    logic [BURST_W-1:0]      low_next;
    logic                    suspend;
    logic                    selected;
    logic                    load_cyc;
    logic                    burst_cyc;
    logic                    cur_write;
    logic [ADDR_W-1:0]       cur_addr;
    logic                    s1_valid_reg;
    logic                    s1_write_reg;
    logic [ADDR_W-1:0]       s1_addr_reg;
    logic [LANES-1:0]        s1_lane_n_reg;
    logic                    s2_valid_reg;
    logic                    s2_write_reg;
    logic [ADDR_W-1:0]       s2_addr_reg;
    logic [LANES-1:0]        s2_lane_n_reg;
    logic [LANES*LANE_W-1:0] bus_word;
    logic [LANES*LANE_W-1:0] fwd_word;

    assign suspend   = CLOCK_SUSPEND_N_IN;
    assign selected  = !SELECT_LOW_FIRST_N_IN && !SELECT_LOW_SECOND_N_IN
                       && SELECT_HIGH_SECOND_IN;
    assign load_cyc  = !ADVANCE_OR_LOAD_IN && selected;
    assign burst_cyc = ADVANCE_OR_LOAD_IN && state_reg != PBSP_IDLE;
    assign cur_write = load_cyc ? !READ_WRITE_N_IN
                                : state_reg == PBSP_WRITE;

    assign cnt_next = cnt_reg + BURST_STEP;
    assign low_next = BURST_ORDER_SELECT_IN ? (base_reg ^ cnt_next)
                                            : (base_reg + cnt_next);

    always_comb
    begin
        cur_addr = ADDR_IN;
        if (!load_cyc)
        begin
            cur_addr = {hi_addr_reg[ADDR_W-1:BURST_W], low_next};
        end
    end

    always_ff @(posedge REF_CLK_IN)
    begin
        if (RESET_IN)
        begin
            state_reg   <= PBSP_IDLE;
            hi_addr_reg <= '0;
            base_reg    <= BURST_CNT_RESET;
            cnt_reg     <= BURST_CNT_RESET;
        end
        else if (!suspend)
        begin
            if (load_cyc)
            begin
                state_reg   <= READ_WRITE_N_IN ? PBSP_READ : PBSP_WRITE;
                hi_addr_reg <= ADDR_IN;
                base_reg    <= ADDR_IN[BURST_W-1:0];
                cnt_reg     <= BURST_CNT_RESET;
            end
            else if (!ADVANCE_OR_LOAD_IN)
            begin
                state_reg <= PBSP_IDLE;
            end
            else if (burst_cyc)
            begin
                cnt_reg <= cnt_next;
            end
        end
    end

    // pipeline stages; a deselect still drains what is already in flight
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RESET_IN)
        begin
            s1_valid_reg  <= 1'b0;
            s1_write_reg  <= 1'b0;
            s1_addr_reg   <= '0;
            s1_lane_n_reg <= '1;
            s2_valid_reg  <= 1'b0;
            s2_write_reg  <= 1'b0;
            s2_addr_reg   <= '0;
            s2_lane_n_reg <= '1;
        end
        else if (!suspend)
        begin
            s1_valid_reg  <= load_cyc || burst_cyc;
            s1_write_reg  <= cur_write;
            s1_addr_reg   <= cur_addr;
            s1_lane_n_reg <= BYTE_LANE_WRITE_N_IN;
            s2_valid_reg  <= s1_valid_reg;
            s2_write_reg  <= s1_write_reg;
            s2_addr_reg   <= s1_addr_reg;
            s2_lane_n_reg <= s1_lane_n_reg;
        end
    end

    for (genvar g = 0; g < LANES; g++)
    begin : g_lane
        // lane g carries byte g plus parity bit g
        assign bus_word[g*LANE_W +: LANE_W] = {PARITY_IN[g], DQ_IN[g*BYTE_W +: BYTE_W]};
        // a write one command ahead lands after the read; forward it per lane
        assign fwd_word[g*LANE_W +: LANE_W] =
            (mif.wr_en && mif.wr_lane[g] && s2_addr_reg == s1_addr_reg)
            ? bus_word[g*LANE_W +: LANE_W] : mif.rd_data[g*LANE_W +: LANE_W];
        always_ff @(posedge REF_CLK_IN)
        begin
            if (RESET_IN)
            begin
                DQ_OUT[g*BYTE_W +: BYTE_W] <= '0;
                PARITY_OUT[g]              <= 1'b0;
            end
            else if (!suspend)
            begin
                DQ_OUT[g*BYTE_W +: BYTE_W] <= fwd_word[g*LANE_W +: BYTE_W];
                PARITY_OUT[g]              <= fwd_word[g*LANE_W + BYTE_W];
            end
        end
    end

    assign mif.wr_en   = !suspend && s2_valid_reg && s2_write_reg
                         && (s2_lane_n_reg != '1);
    assign mif.wr_addr = s2_addr_reg;
    assign mif.wr_lane = ~s2_lane_n_reg;
    assign mif.wr_data = bus_word;
    assign mif.rd_en   = !suspend && (load_cyc || burst_cyc) && !cur_write;
    assign mif.rd_addr = cur_addr;

    // output enable is sampled at the edge, not used as an asynchronous gate
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RESET_IN)
        begin
            DATA_OE_N_OUT <= OE_N_RESET;
        end
        else if (!suspend)
        begin
            DATA_OE_N_OUT <= !(s1_valid_reg && !s1_write_reg
                               && !OUTPUT_ENABLE_N_IN);
        end
    end

    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (RESET_IN);

    sequence load_read_s;
        load_cyc && READ_WRITE_N_IN && !suspend;
    endsequence
    sequence load_ok_s;
        load_cyc && !suspend;
    endsequence
    sequence burst_ok_s;
        burst_cyc && !suspend;
    endsequence

    chk_read_latency: assert property (load_read_s ##1 (!suspend && !OUTPUT_ENABLE_N_IN)
        |=> !DATA_OE_N_OUT) else $error("read data not driven two cycles after load");
    chk_deselect_float: assert property ((!ADVANCE_OR_LOAD_IN && !selected && !suspend)
        ##1 !suspend |=> DATA_OE_N_OUT) else $error("bus not floated after deselect");
    chk_noop_float: assert property ((ADVANCE_OR_LOAD_IN && state_reg == PBSP_IDLE
        && !suspend) ##1 !suspend |=> DATA_OE_N_OUT) else $error("no-op slot driven");
    chk_suspend_hold: assert property (suspend |=> $stable(DQ_OUT)
        && $stable(DATA_OE_N_OUT) && $stable(cnt_reg)) else $error("suspend moved state");
    chk_interleave_step: assert property (load_ok_s ##1 (burst_ok_s and BURST_ORDER_SELECT_IN)
        |-> cur_addr[1:0] == ($past(ADDR_IN[1:0]) ^ 2'h1)) else $error("bad interleaved beat");
    chk_linear_step: assert property (load_ok_s ##1 (burst_ok_s and !BURST_ORDER_SELECT_IN)
        |-> cur_addr[1:0] == $past(ADDR_IN[1:0]) + 2'h1) else $error("bad linear beat");
    chk_burst_wrap: assert property (load_ok_s ##1 burst_ok_s [*4]
        |-> cur_addr[1:0] == $past(ADDR_IN[1:0], 4)) else $error("burst did not wrap");
    chk_write_burst: assert property ((load_ok_s and !READ_WRITE_N_IN) ##1 burst_ok_s
        |-> !mif.rd_en ##2 (suspend || s2_write_reg)) else $error("write burst turned read");
    chk_lane_write: assert property ((s2_valid_reg && s2_write_reg
        && !suspend && !s2_lane_n_reg[0])
        |=> u_mem.store[0][$past(s2_addr_reg)] == $past(bus_word[LANE_W-1:0]))
        else $error("enabled lane not written");
    chk_lane_masked: assert property ((s2_valid_reg && s2_write_reg
        && !suspend && s2_lane_n_reg[0])
        |=> u_mem.store[0][$past(s2_addr_reg)] == $past(u_mem.store[0][s2_addr_reg]))
        else $error("masked lane written");
    // reset itself is the antecedent, so the default disable must not apply here
    chk_reset_float: assert property (disable iff (1'b0) RESET_IN |=> DATA_OE_N_OUT)
        else $error("outputs driven after reset");
endmodule

// ### dv/pbsp_bus_model.sv
module pbsp_bus_model
(
    input  wire logic        clk_in,
    input  wire logic        ctrl_en_in,
    input  wire logic [35:0] ctrl_in,
    input  wire logic        dev_oe_n_in,
    input  wire logic [35:0] dev_in,
    output logic      [35:0] bus_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [35:0] last_reg = 36'h0;
    // no pull on the lines: a floating bus must not look like the last data
    always_comb bus_out = !dev_oe_n_in ? dev_in : (ctrl_en_in ? ctrl_in : ~last_reg);
    always_ff @(posedge clk_in) last_reg <= bus_out;
endmodule

// ### dv/pbsp_port_tb.sv
module pbsp_port_tb;
    import pbsp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int AW = 6;
    logic          clk = 1'b0;
    logic          rst = 1'b1;
    logic          adv = 1'b0, rw = 1'b1, sus = 1'b0, ord = 1'b1, oen = 1'b0, wen = 1'b0;
    logic [2:0]    sel = 3'h0;
    logic [3:0]    lan = 4'hf;
    logic [AW-1:0] adr = 6'h0;
    logic [35:0]   wdat = 36'h0, bus, ed = 36'h0, cap = 36'h0;
    logic [31:0]   dq_o;
    logic [3:0]    par_o;
    logic          oe_o;
    // reference state: stage kinds 0 none, 1 read, 2 write
    logic [35:0]   m [64];
    logic [1:0]    k1 = 2'h0, k2 = 2'h0, cnt = 2'h0;
    logic [5:0]    a1 = 6'h0, a2 = 6'h0, base = 6'h0;
    logic [3:0]    l1 = 4'hf, l2 = 4'hf;
    logic          act = 1'b0, dir = 1'b1, eo = 1'b1;
    logic [7:0]    stamp = 8'h1;
    int            errors = 0;
    int            checked = 0;

    always #50 clk = ~clk;

    pbsp_port #(.LANES(4), .ADDR_W(AW)) i_pbsp_port (
        .REF_CLK_IN(clk), .RESET_IN(rst), .ADDR_IN(adr), .READ_WRITE_N_IN(rw),
        .ADVANCE_OR_LOAD_IN(adv), .CLOCK_SUSPEND_N_IN(sus), .SELECT_LOW_FIRST_N_IN(sel[2]),
        .SELECT_LOW_SECOND_N_IN(sel[1]), .SELECT_HIGH_SECOND_IN(sel[0]),
        .BYTE_LANE_WRITE_N_IN(lan), .BURST_ORDER_SELECT_IN(ord), .OUTPUT_ENABLE_N_IN(oen),
        .DQ_IN(bus[31:0]), .PARITY_IN(bus[35:32]), .DQ_OUT(dq_o), .PARITY_OUT(par_o),
        .DATA_OE_N_OUT(oe_o));

    pbsp_bus_model i_pbsp_bus_model (.clk_in(clk), .ctrl_en_in(wen), .ctrl_in(wdat),
        .dev_oe_n_in(oe_o), .dev_in({par_o, dq_o}), .bus_out(bus));

    task automatic conclude();
        $display("checked %0d, errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic cmp_oe(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: drive enable %b, want %b", $time, got, exp);
        end
    endtask

    task automatic cmp_data(input logic [35:0] got, input logic [35:0] exp);
        checked++;
        if (got !== exp || $isunknown(exp))
        begin
            errors++;
            $display("unexpected at %0t: read data %h, want %h", $time, got, exp);
        end
    endtask

    // one cycle: check what the ending cycle shows, step the reference, present a command
    task automatic issue(input logic v, input logic r, input logic [2:0] s,
                         input logic [3:0] l, input logic [5:0] a, input logic h);
        @(negedge clk);
        cmp_oe(oe_o, eo);
        if (!eo)
            cmp_data({par_o, dq_o}, ed);
        cap = bus;
        @(posedge clk);
        if (!sus)
        begin
            if (k2 == 2'h2)
                for (int g = 0; g < 4; g++)
                    if (!l2[g])
                    begin
                        m[a2][8*g +: 8] = cap[8*g +: 8];
                        m[a2][32+g] = cap[32+g];
                    end
            eo = !(k1 == 2'h1 && !oen);
            ed = m[a1];
            k2 = k1;
            a2 = a1;
            l2 = l1;
            k1 = 2'h0;
            if (!adv && sel == 3'h1)
            begin
                act = 1'b1;
                dir = rw;
                base = adr;
                cnt = 2'h0;
            end
            else if (!adv)
                act = 1'b0;
            else if (act)
                cnt = cnt + 2'h1;
            if (act)
            begin
                k1 = dir ? 2'h1 : 2'h2;
                a1 = {base[5:2], ord ? base[1:0] ^ cnt : base[1:0] + cnt};
                l1 = lan;
            end
            wen <= (k2 == 2'h2);
            wdat <= {stamp[3:0], stamp, ~stamp, stamp ^ 8'h5a, stamp + 8'h33};
            stamp = stamp + 8'h1;
        end
        adv <= v;
        rw <= r;
        sel <= s;
        lan <= l;
        adr <= a;
        sus <= h;
    endtask

    task automatic ld(input logic w, input logic [3:0] l, input logic [5:0] a);
        issue(1'b0, !w, 3'h1, l, a, 1'b0);
    endtask

    // advance cycles carry false selects and a toggling direction, both ignored
    task automatic step(input int n);
        for (int i = 0; i < n; i++)
            issue(1'b1, i[0], 3'h6, 4'h0, 6'h3f, 1'b0);
    endtask

    task automatic ds(input logic [2:0] s);
        issue(1'b0, 1'b1, s, 4'hf, 6'h0, 1'b0);
    endtask

    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (3) ds(3'h0);
        $display("test idle done");
        for (int a = 0; a < 16; a++)
            ld(1'b1, 4'h0, a[5:0]);
        for (int a = 0; a < 16; a++)
            ld(1'b1, a[3:0], a[5:0]);
        // read right behind a partial write, then two behind one
        ld(1'b1, 4'h5, 6'h3);
        ld(1'b0, 4'h0, 6'h3);
        ld(1'b1, 4'ha, 6'h3);
        ld(1'b1, 4'h0, 6'h4);
        ld(1'b0, 4'h0, 6'h3);
        $display("test lane writes done");
        for (int o = 0; o < 2; o++)
            for (int b = 0; b < 4; b++)
            begin
                ord <= o[0];
                ld(1'b0, 4'h0, 6'(4 * o + b));
                step(5);
            end
        ord <= 1'b1;
        $display("test bursts done");
        ld(1'b1, 4'h0, 6'h22);
        step(3);
        ld(1'b0, 4'h0, 6'h22);
        step(1);
        oen <= 1'b1;
        step(1);
        oen <= 1'b0;
        step(1);
        $display("test write burst done");
        for (int i = 0; i < 3; i++)
        begin
            ld(1'b0, 4'h0, 6'h1);
            step(1);
            ds(i == 0 ? 3'h5 : (i == 1 ? 3'h3 : 3'h0));
            step(2);
        end
        $display("test deselect done");
        ld(1'b0, 4'h0, 6'h20);
        step(1);
        repeat (3) issue(1'b0, 1'b0, 3'h1, 4'h0, 6'h2a, 1'b1);
        step(2);
        ld(1'b1, 4'h3, 6'h20);
        repeat (2) issue(1'b1, 1'b0, 3'h1, 4'h0, 6'h2a, 1'b1);
        ds(3'h0);
        ld(1'b0, 4'h0, 6'h20);
        repeat (3) ds(3'h0);
        $display("test suspend done");
        conclude();
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        errors++;
        conclude();
    end
endmodule
